// File: design/bfcd_bridge_decoder.sv
`timescale 1ns/1ps
`include "bfcd_defs.svh"
module bfcd_bridge_decoder #(
   // arbitrary fixed upper address bits
   parameter logic [3:0] ADDR_FIXED = 4'h2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic [2:0] addr_pins_i,
   output logic int_o,
   output logic int_oe_n_o,
   input wire logic [3:0] sel_in_i,
   output logic [3:0] sel_out_o,
   output logic [3:0] sel_oe_n_o,
   output logic serial_clock_out_o,
   output logic mosi_o,
   input wire logic miso_i,
   output logic low_power_o
);
   localparam int DEPTH = `BFCD_BUF_DEPTH;
   localparam logic [7:0] NB_MAX = 8'(DEPTH + 1);
   localparam logic [9:0] HALF0 = 10'(`BFCD_HALF_CYC(`BFCD_RATE0_KHZ));
   localparam logic [9:0] HALF1 = 10'(`BFCD_HALF_CYC(`BFCD_RATE1_KHZ));
   localparam logic [9:0] HALF2 = 10'(`BFCD_HALF_CYC(`BFCD_RATE2_KHZ));
   localparam logic [9:0] HALF3 = 10'(`BFCD_HALF_CYC(`BFCD_RATE3_KHZ));

   function automatic logic [2:0] bfcd_pos(input logic [2:0] n,
                                           input logic lsb);
      return lsb ? n : 3'h7 - n;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pins in, straps, two-wire slave
   logic [9:0] sy_w;
   logic [2:0] addr_q;
   logic [1:0] strap_cnt_q;
   bfcd_pkg::bfcd_i2c_ev_t ev;
   bfcd_pkg::bfcd_mode_t mode_q;
   logic [7:0] buf_q [DEPTH];
   logic [7:0] rd_ptr_q;

   bfcd_sync #(.W(10), .RST_VAL(`BFCD_SYNC_RESET)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({sel_in_i, addr_pins_i, miso_i, scl_i, sda_i}),
      .q_o(sy_w)
   );
   wire sda_s = sy_w[0];
   wire scl_s = sy_w[1];
   wire miso_s = sy_w[2];
   wire [2:0] addr_s = sy_w[5:3];
   wire [3:0] pins_s = sy_w[9:6];
   wire busy_w = (mode_q == bfcd_pkg::MODE_RUN);
   wire [7:0] rd_data_w = (rd_ptr_q < 8'(DEPTH)) ? buf_q[rd_ptr_q] : 8'h00;

   bfcd_i2c_slave u_i2c (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .scl_i(scl_s),
      .sda_i(sda_s),
      .own_addr_i({ADDR_FIXED, addr_q}),
      .busy_i(busy_w),
      .rd_data_i(rd_data_w),
      .ev_o(ev),
      .sda_oe_n_o(sda_oe_n_o)
   );
   assign sda_o = 1'b0;

   // straps follow the synchroniser until it has flushed its reset value,
   // then hold, so later pin moves are ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_q <= 3'h0;
         strap_cnt_q <= 2'h0;
      end else if (ce_i && strap_cnt_q != `BFCD_STRAP_WAIT) begin
         addr_q <= addr_s;
         strap_cnt_q <= strap_cnt_q + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // message tracking and function decode
   logic msg_wr_q;
   logic [7:0] nbytes_q, fn_q, arg_q;
   wire ours_w = ev.addr_hit & ~busy_w;
   wire exec_w = ce_i & ev.stop & msg_wr_q & (nbytes_q != 8'h00) & ~busy_w;
   wire has_arg = (nbytes_q >= 8'h02);
   wire is_xfer = (fn_q[7:4] == 4'h0) & (fn_q[3:0] != 4'h0);
   wire do_xfer = exec_w & is_xfer;
   wire do_setup = exec_w & has_arg & (fn_q == `BFCD_FN_SETUP);
   wire do_clr = exec_w & (fn_q == `BFCD_FN_CLRINT);
   wire do_idle = exec_w & (fn_q == `BFCD_FN_IDLE);
   wire do_pinwr = exec_w & has_arg & (fn_q == `BFCD_FN_PINWR);
   wire do_pinrd = exec_w & (fn_q == `BFCD_FN_PINRD);
   wire do_role = exec_w & has_arg & (fn_q == `BFCD_FN_ROLE);
   wire do_type = exec_w & has_arg & (fn_q == `BFCD_FN_TYPE);
   wire i2c_we = ce_i & ev.byte_valid & msg_wr_q & is_xfer &
                 (nbytes_q != 8'h00) & (nbytes_q <= 8'(DEPTH));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msg_wr_q <= 1'b0;
         nbytes_q <= 8'h00;
         fn_q <= 8'h00;
         arg_q <= 8'h00;
      end else if (ce_i) begin
         if (ev.start || ev.stop) begin
            msg_wr_q <= 1'b0;
            nbytes_q <= 8'h00;
         end else if (ours_w) begin
            msg_wr_q <= ~ev.rw;
         end else if (ev.byte_valid && msg_wr_q) begin
            if (nbytes_q == 8'h00) begin
               fn_q <= ev.data;
            end
            if (nbytes_q == 8'h01) begin
               arg_q <= ev.data;
            end
            if (nbytes_q != NB_MAX) begin
               nbytes_q <= nbytes_q + 8'h01;
            end
         end
      end
   end

   // read pointer restarts at byte zero on every read address that is acknowledged (not while busy)
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_ptr_q <= 8'h00;
      end else if (ce_i) begin
         if (ours_w && ev.rw) begin
            rd_ptr_q <= 8'h00; // [RULE_01] [RULE_15]
         end else if (ev.rd_take && rd_ptr_q != 8'(DEPTH)) begin
            rd_ptr_q <= rd_ptr_q + 8'h01; // [RULE_01]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration and pin control
   bfcd_pkg::bfcd_setup_t setup_q;
   logic [3:0] latch_q, role_q, sel_mask_q;
   logic [7:0] type_q;
   wire [7:0] quasi_clr_w;
   logic int_q;
   logic spi_fin_w;

   for (genvar i = 0; i < 4; i++) begin : g_pin
      wire [1:0] ty = type_q[2*i+1 -: 2];
      wire ss_on = busy_w & sel_mask_q[i];
      wire rel = (ty == `BFCD_TYPE_INPUT) |
                 (ty != `BFCD_TYPE_PUSH & latch_q[i]);
      assign quasi_clr_w[2*i+1 -: 2] = {2{arg_q[i] & ~role_q[i]}};
      assign sel_out_o[i] = role_q[i] ? latch_q[i] : ~ss_on; // [RULE_21]
      assign sel_oe_n_o[i] = role_q[i] & rel;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setup_q <= `BFCD_SETUP_RESET; // [RULE_23]
         latch_q <= `BFCD_LATCH_RESET;
         role_q <= `BFCD_ROLE_RESET; // [RULE_16]
         type_q <= `BFCD_TYPE_RESET;
      end else if (ce_i) begin
         if (do_setup) begin
            setup_q <= arg_q & `BFCD_SETUP_MASK; // [RULE_03] [RULE_22]
         end
         if (do_pinwr) begin
            latch_q <= (arg_q[3:0] & role_q) | (latch_q & ~role_q); // [RULE_12]
         end
         if (do_role) begin
            role_q <= arg_q[3:0]; // [RULE_17] [RULE_22]
            type_q <= type_q & ~quasi_clr_w; // [RULE_18]
         end else if (do_type) begin
            type_q <= arg_q; // [RULE_19]
         end
      end
   end

   // a finish in the same cycle as a clear keeps the interrupt asserted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_q <= 1'b0;
      end else if (ce_i) begin
         if (spi_fin_w) begin
            int_q <= 1'b1; // [RULE_07]
         end else if (do_clr) begin
            int_q <= 1'b0; // [RULE_08]
         end
      end
   end
   assign int_o = 1'b0;
   assign int_oe_n_o = ~int_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= bfcd_pkg::MODE_READY;
      end else if (ce_i) begin
         case (mode_q)
            bfcd_pkg::MODE_READY: begin
               if (do_xfer) begin
                  mode_q <= bfcd_pkg::MODE_RUN; // [RULE_20] [RULE_21]
               end else if (do_idle) begin
                  mode_q <= bfcd_pkg::MODE_LOW; // [RULE_10]
               end
            end
            bfcd_pkg::MODE_RUN: begin
               if (spi_fin_w) begin
                  mode_q <= bfcd_pkg::MODE_READY;
               end
            end
            bfcd_pkg::MODE_LOW: begin
               if (ev.addr_hit) begin
                  mode_q <= bfcd_pkg::MODE_READY; // [RULE_11]
               end
            end
            default: mode_q <= bfcd_pkg::MODE_READY;
         endcase
      end
   end
   assign low_power_o = (mode_q == bfcd_pkg::MODE_LOW);

   ////////////////////////////////////////////////////////////////////////
   // serial transfer engine, works in place on the buffer
   logic [7:0] spi_cnt_q, spi_idx_q, rx_q, rx_d;
   logic [9:0] div_q, half_w;
   logic [3:0] edge_q;
   logic sclk_q;

   assign half_w = (setup_q.rate == 2'h0) ? HALF0 :
                   (setup_q.rate == 2'h1) ? HALF1 :
                   (setup_q.rate == 2'h2) ? HALF2 : HALF3; // [RULE_06]
   // formats 00 and 11 sample on the leading edge (even edge count)
   wire samp_lead_w = ~(setup_q.fmt[1] ^ setup_q.fmt[0]); // [RULE_05]
   wire [3:0] edge_m1 = edge_q - 4'h1;
   wire [2:0] out_bit_w = (samp_lead_w || edge_q == 4'h0) ? edge_q[3:1]
                                                           : edge_m1[3:1];
   wire [7:0] tx_w = (spi_idx_q < 8'(DEPTH)) ? buf_q[spi_idx_q] : 8'h00;
   assign spi_fin_w = ce_i & busy_w & (spi_idx_q == spi_cnt_q);
   wire tick_w = busy_w & ~spi_fin_w & (div_q == half_w - 10'h001);
   wire samp_w = tick_w & (edge_q[0] ^ samp_lead_w);
   wire [2:0] in_pos_w = bfcd_pos(edge_q[3:1], setup_q.lsb_first);
   wire spi_we = ce_i & tick_w & (edge_q == 4'hf);

   always_comb begin
      rx_d = rx_q;
      if (samp_w) begin
         rx_d[in_pos_w] = miso_s;
      end
   end

   assign mosi_o = busy_w &
       tx_w[bfcd_pos(out_bit_w, setup_q.lsb_first)]; // [RULE_04]
   assign serial_clock_out_o = sclk_q ^ setup_q.fmt[1]; // [RULE_05]

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spi_cnt_q <= 8'h00;
         spi_idx_q <= 8'h00;
         sel_mask_q <= 4'h0;
         rx_q <= 8'h00;
         div_q <= 10'h000;
         edge_q <= 4'h0;
         sclk_q <= 1'b0;
      end else if (ce_i) begin
         rx_q <= rx_d;
         if (do_xfer) begin
            spi_cnt_q <= nbytes_q - 8'h01; // [RULE_21]
            sel_mask_q <= fn_q[3:0];
            spi_idx_q <= 8'h00;
            div_q <= 10'h000;
            edge_q <= 4'h0;
            sclk_q <= 1'b0;
         end else if (tick_w) begin
            div_q <= 10'h000;
            sclk_q <= ~sclk_q;
            edge_q <= edge_q + 4'h1;
            if (edge_q == 4'hf) begin
               spi_idx_q <= spi_idx_q + 8'h01;
            end
         end else if (busy_w) begin
            div_q <= div_q + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // buffer, one write port; bus reads never write [RULE_02]
   wire buf_we = i2c_we | spi_we | do_pinrd;
   wire [7:0] buf_wi = spi_we ? spi_idx_q :
                       do_pinrd ? 8'h00 : nbytes_q - 8'h01;
   // raw pin levels: bits of select lines are meaningless [RULE_14]
   wire [7:0] buf_wd = spi_we ? rx_d :
                       do_pinrd ? {4'h0, pins_s} : ev.data; // [RULE_13]

   always_ff @(posedge clk_i) begin
      if (ce_i && buf_we) begin
         buf_q[buf_wi] <= buf_wd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   sequence s_exec(logic [7:0] code);
      exec_w && fn_q == code;
   endsequence

   int_set_a: assert property ( // [RULE_07]
      spi_fin_w |=> !int_oe_n_o)
      else $error("interrupt not asserted after transfer end");
   int_clear_a: assert property ( // [RULE_08]
      s_exec(`BFCD_FN_CLRINT) ##0 !spi_fin_w |=> int_oe_n_o)
      else $error("interrupt not released by clear");
   setup_store_a: assert property ( // [RULE_03]
      s_exec(`BFCD_FN_SETUP) ##0 has_arg |=>
      setup_q == ($past(arg_q) & `BFCD_SETUP_MASK))
      else $error("setup byte not stored");
   sequence s_wake;
      low_power_o && ev.addr_hit;
   endsequence

   idle_wake_a: assert property ( // [RULE_11]
      s_wake |=> !low_power_o)
      else $error("idle not left on own address");
   read_keep_a: assert property ( // [RULE_02]
      ev.rd_take |-> !buf_we)
      else $error("buffer written during a read");
   sel_active_a: assert property ( // [RULE_21]
      busy_w |-> (sel_out_o & sel_mask_q & ~role_q) == 4'h0)
      else $error("selected line not low during transfer");
   clk_rate_a: assert property ( // [RULE_06]
      busy_w && $changed(sclk_q) |-> $past(div_q) == half_w - 10'h001)
      else $error("clock half period wrong");
   clk_idle_a: assert property ( // [RULE_05]
      !busy_w |-> serial_clock_out_o == setup_q.fmt[1])
      else $error("clock idle level wrong");
   pin_sample_a: assert property ( // [RULE_13]
      s_exec(`BFCD_FN_PINRD) |=> buf_q[0][3:0] == $past(pins_s))
      else $error("pin sample not stored");
   new_quasi_a: assert property ( // [RULE_18]
      do_role && arg_q[0] && !role_q[0] |=> type_q[1:0] == `BFCD_TYPE_QUASI)
      else $error("new pin not quasi type");
   busy_nack_a: assert property ( // [RULE_20]
      busy_w && ev.addr_hit |-> ##1 sda_oe_n_o [*2])
      else $error("address acknowledged while busy");
endmodule // bfcd_bridge_decoder

// File: design/bfcd_defs.svh
`ifndef BFCD_DEFS_SVH
`define BFCD_DEFS_SVH
// Notes on behaviour
// RULE_01: an addressed read returns buffer bytes in order, no function byte.
// RULE_02: reading the buffer over the bus never alters its contents.
// RULE_03: function f0h plus one byte stores the transfer setup.
// RULE_04: setup bit 5 low sends msb first, high sends lsb first.
// RULE_05: setup bits 3:2 pick idle clock level and sampling edge.
// RULE_06: setup bits 1:0 pick 1843, 461, 115 or 58 khz clock.
// RULE_07: the interrupt output asserts low when a transfer finishes.
// RULE_08: function f1h releases the interrupt output high.
// RULE_09: a polling master may never send the clear command.
// RULE_10: function f2h puts the device into low-power idle.
// RULE_11: low-power idle ends when the own slave address is seen.
// RULE_12: function f4h sets output latches of lines that are pins.
// RULE_13: function f5h samples line states into buffer byte zero.
// RULE_14: sampled bits of lines that are not pins are undefined.
// RULE_15: master reads pins by sample command then one-byte read.
// RULE_16: after reset all four lines act as slave selects.
// RULE_17: function f6h: a one bit makes that line a pin.
// RULE_18: lines newly made pins default to quasi-bidirectional type.
// RULE_19: function f7h sets two type bits per line, line 3 highest.
// RULE_20: after stop, traffic is refused until the function finishes.
// RULE_21: functions 01h to 0fh send the buffer, low bits pick selects.
// RULE_22: reserved bits of setup and pin bytes have no effect.
// RULE_23: after reset the setup is all zero.

`define BFCD_CLK_KHZ 100000
`define BFCD_FN_SETUP 8'hf0
`define BFCD_FN_CLRINT 8'hf1
`define BFCD_FN_IDLE 8'hf2
`define BFCD_FN_PINWR 8'hf4
`define BFCD_FN_PINRD 8'hf5
`define BFCD_FN_ROLE 8'hf6
`define BFCD_FN_TYPE 8'hf7
`define BFCD_BUF_DEPTH 200
`define BFCD_SETUP_MASK 8'h2f
`define BFCD_SETUP_RESET 8'h00
`define BFCD_LATCH_RESET 4'h0
`define BFCD_ROLE_RESET 4'h0
`define BFCD_TYPE_RESET 8'h00
`define BFCD_TYPE_QUASI 2'h0
`define BFCD_TYPE_PUSH 2'h1
`define BFCD_TYPE_INPUT 2'h2
`define BFCD_TYPE_OPEN 2'h3
`define BFCD_RATE0_KHZ 1843
`define BFCD_RATE1_KHZ 461
`define BFCD_RATE2_KHZ 115
`define BFCD_RATE3_KHZ 58
`define BFCD_HALF_CYC(k) ((`BFCD_CLK_KHZ + 2 * (k) - 1) / (2 * (k)))
`define BFCD_SYNC_RESET 10'h003
`define BFCD_STRAP_WAIT 2'h3
`endif

// File: design/bfcd_pkg.sv
package bfcd_pkg;
   typedef struct packed {
      logic start;
      logic stop;
      logic addr_hit;
      logic rw;
      logic byte_valid;
      logic [7:0] data;
      logic rd_take;
   } bfcd_i2c_ev_t;

   typedef struct packed {
      logic [1:0] rsv_hi;
      logic lsb_first;
      logic rsv_mid;
      logic [1:0] fmt;
      logic [1:0] rate;
   } bfcd_setup_t;

   typedef enum logic [1:0] {MODE_READY, MODE_RUN, MODE_LOW} bfcd_mode_t;

   typedef enum logic [2:0] {
      I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_RX, I2C_TX, I2C_TXACK
   } bfcd_i2c_st_t;
endpackage

// File: design/bfcd_sync.sv
`timescale 1ns/1ps
module bfcd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL;
         q_o <= RST_VAL;
      end else if (ce_i) begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule // bfcd_sync

// File: design/bfcd_i2c_slave.sv
`timescale 1ns/1ps
module bfcd_i2c_slave (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [6:0] own_addr_i,
   input wire logic busy_i,
   input wire logic [7:0] rd_data_i,
   output bfcd_pkg::bfcd_i2c_ev_t ev_o,
   output logic sda_oe_n_o
);
   bfcd_pkg::bfcd_i2c_st_t st_q;
   logic scl_q, sda_q, rw_q, nack_q, drive_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;

   wire scl_rise = scl_i & ~scl_q;
   wire scl_fall = ~scl_i & scl_q;
   wire start_w = scl_i & scl_q & sda_q & ~sda_i;
   wire stop_w = scl_i & scl_q & ~sda_q & sda_i;
   wire byte_w = scl_fall & (bit_q == 4'h8);
   wire in_addr = (st_q == bfcd_pkg::I2C_ADDR);
   wire hit_w = in_addr & byte_w & (sh_q[7:1] == own_addr_i);
   wire load_w = scl_fall & ((st_q == bfcd_pkg::I2C_ACK & rw_q) |
                  (st_q == bfcd_pkg::I2C_TXACK & ~nack_q));

   assign ev_o.start = start_w;
   assign ev_o.stop = stop_w;
   assign ev_o.addr_hit = hit_w;
   assign ev_o.rw = sh_q[0];
   assign ev_o.byte_valid = byte_w & (st_q == bfcd_pkg::I2C_RX);
   assign ev_o.data = sh_q;
   assign ev_o.rd_take = load_w & ~start_w & ~stop_w;
   assign sda_oe_n_o = ~drive_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= bfcd_pkg::I2C_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         drive_q <= 1'b0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
      end else if (ce_i) begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         if (start_w) begin
            st_q <= bfcd_pkg::I2C_ADDR;
            bit_q <= 4'h0;
            drive_q <= 1'b0;
         end else if (stop_w) begin
            st_q <= bfcd_pkg::I2C_IDLE;
            drive_q <= 1'b0;
         end else if (load_w) begin
            st_q <= bfcd_pkg::I2C_TX;
            sh_q <= rd_data_i;
            bit_q <= 4'h0;
            nack_q <= 1'b0;
            drive_q <= ~rd_data_i[7];
         end else begin
            case (st_q)
               bfcd_pkg::I2C_ADDR, bfcd_pkg::I2C_RX: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_i};
                     bit_q <= bit_q + 4'h1;
                  end else if (byte_w) begin
                     // busy: address is not acknowledged [RULE_20]
                     if (!in_addr || (hit_w && !busy_i)) begin
                        st_q <= bfcd_pkg::I2C_ACK;
                        drive_q <= 1'b1;
                        if (in_addr) begin
                           rw_q <= sh_q[0];
                        end
                     end else begin
                        st_q <= bfcd_pkg::I2C_IDLE;
                     end
                  end
               end
               bfcd_pkg::I2C_ACK: begin
                  if (scl_fall) begin
                     st_q <= bfcd_pkg::I2C_RX;
                     bit_q <= 4'h0;
                     drive_q <= 1'b0;
                  end
               end
               bfcd_pkg::I2C_TX: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h7) begin
                        st_q <= bfcd_pkg::I2C_TXACK;
                        drive_q <= 1'b0;
                     end else begin
                        bit_q <= bit_q + 4'h1;
                        sh_q <= {sh_q[6:0], 1'b0};
                        drive_q <= ~sh_q[6];
                     end
                  end
               end
               bfcd_pkg::I2C_TXACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_i;
                  end else if (scl_fall) begin
                     st_q <= bfcd_pkg::I2C_IDLE;
                  end
               end
               default: st_q <= bfcd_pkg::I2C_IDLE;
            endcase
         end
      end
   end
endmodule // bfcd_i2c_slave

// File: testbench/bfcd_i2c_master_model.sv
`timescale 1ns/1ps
// two-wire master; scl stands high and sda released between frames
module bfcd_i2c_master_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic start();
      w(4); sda_o = 1'b1; scl_o = 1'b1; w(4); sda_o = 1'b0; w(4);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      w(4); sda_o = 1'b0; w(4); scl_o = 1'b1; w(4); sda_o = 1'b1; w(4);
   endtask
   // 16 cycles a bit; data moves mid low phase, sampled mid high phase
   task automatic bit_io(input logic b, output logic s);
      w(4); sda_o = b; w(4); scl_o = 1'b1; w(4); s = sda_i; w(4);
      scl_o = 1'b0;
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   // one byte per call; last high ends the read with a nack, low acks
   task automatic rd_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(last, s);
   endtask
endmodule // bfcd_i2c_master_model

// File: testbench/bfcd_bridge_decoder_tb.sv
`timescale 1ns/1ps
module bfcd_bridge_decoder_tb;
   localparam logic [6:0] ADR = {4'h2, 3'h3};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] fmt = 2'h0;
   logic [7:0] cap = 8'h00;
   logic sck_q = 1'b0;
   logic ack;
   logic [7:0] rb;
   int hc = 0;
   int half = 0;
   int fails = 0;
   int n_tests = 0;
   wire m_scl, m_sda, sda_o, sda_oe_n_o, int_o, int_oe_n_o, sck, mosi, lp;
   wire [3:0] sel_out_o, sel_oe_n_o;
   wire sda_w = m_sda & sda_oe_n_o;
   // released lines float up through the pull-up
   wire [3:0] sel_pin = sel_out_o | sel_oe_n_o;
   initial forever #5 clk_i = ~clk_i;
   bfcd_i2c_master_model u_bfcd_i2c_master_model (.clk_i(clk_i),
      .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
   bfcd_bridge_decoder u_bfcd_bridge_decoder (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .addr_pins_i(3'h3), .int_o(int_o),
      .int_oe_n_o(int_oe_n_o), .sel_in_i(sel_pin), .sel_out_o(sel_out_o),
      .sel_oe_n_o(sel_oe_n_o), .serial_clock_out_o(sck), .mosi_o(mosi),
      .miso_i(mosi), .low_power_o(lp));
   ////////////////////////////////////////////////////////////////////////
   // edge spacing and bits taken at the sampling edge of the format
   always @(negedge clk_i) begin
      sck_q <= sck;
      hc <= hc + 1;
      if (sck !== sck_q) begin
         half <= hc;
         hc <= 1;
         if ((sck != fmt[1]) == (fmt == 2'h0 || fmt == 2'h3))
            cap <= {cap[6:0], mosi};
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic msg(input logic [7:0] fn, d, input int nd);
      u_bfcd_i2c_master_model.start();
      u_bfcd_i2c_master_model.wr_byte({ADR, 1'b0}, ack);
      chk("addr ack", ack, 1'b1);
      u_bfcd_i2c_master_model.wr_byte(fn, ack);
      if (nd > 0) u_bfcd_i2c_master_model.wr_byte(d, ack);
      u_bfcd_i2c_master_model.stop();
   endtask
   task automatic rd1(output logic [7:0] b);
      u_bfcd_i2c_master_model.start();
      u_bfcd_i2c_master_model.wr_byte({ADR, 1'b1}, ack);
      u_bfcd_i2c_master_model.rd_byte(1'b1, b);
      u_bfcd_i2c_master_model.stop();
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("sel out", sel_out_o, 4'hf);
      chk("sel oe", sel_oe_n_o, 4'h0);
      chk("int", int_oe_n_o, 1'b1);
      chk("sck idle", sck, 1'b0);
      chk("int pin", int_o, 1'b0);
      chk("sda pin", sda_o, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_xfer(input logic [7:0] su, ex, input int hp);
      int n;
      fmt = su[3:2];
      msg(8'hf0, su, 1);
      chk("sck idle", sck, su[3]);
      msg(8'h01, 8'h96, 1);
      chk("select", sel_out_o[1:0], 2'h2);
      // device still shifting, so its address goes unanswered
      u_bfcd_i2c_master_model.start();
      u_bfcd_i2c_master_model.wr_byte({ADR, 1'b0}, ack);
      chk("busy nack", ack, 1'b0);
      u_bfcd_i2c_master_model.stop();
      n = 0;
      while (sel_out_o[0] !== 1'b1 && n < 20000) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 20000) begin
         fails++;
         close_out();
      end
      repeat (3) @(negedge clk_i);
      chk("bits", cap, ex);
      chk("half", half[15:0], hp[15:0]);
      chk("int", int_oe_n_o, 1'b0);
      // serial data loops back, so the received byte equals the sent one
      rd1(rb);
      chk("rd", rb, 8'h96);
      rd1(rb);
      chk("rd again", rb, 8'h96);
      $display("test transfer done");
   endtask
   task automatic t_pins();
      msg(8'hf1, 8'h00, 0);
      chk("int clr", int_oe_n_o, 1'b1);
      msg(8'hf6, 8'hf5, 1);
      msg(8'hf4, 8'hf1, 1);
      chk("pin out", sel_out_o, 4'hb);
      chk("pin oe", sel_oe_n_o, 4'h1);
      for (int c = 0; c < 4; c++) begin
         msg(8'hf7, {6'h00, c[1:0]}, 1);
         chk("type oe", sel_oe_n_o[0], c != 1);
      end
      msg(8'hf5, 8'h00, 0);
      rd1(rb);
      chk("sample", rb & 8'h05, 8'h01);
      $display("test pins done");
   endtask
   task automatic t_idle();
      msg(8'hf2, 8'h00, 0);
      chk("idle", lp, 1'b1);
      msg(8'hf1, 8'h00, 0);
      chk("wake", lp, 1'b0);
      $display("test idle done");
   endtask
   initial begin
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (6) @(negedge clk_i);
      t_reset();
      t_xfer(8'hec, 8'h69, 28);
      t_xfer(8'h06, 8'h96, 435);
      t_pins();
      t_idle();
      close_out();
   end
endmodule // bfcd_bridge_decoder_tb
